// >>> common/uhec_pkg.sv
// ****************************************************************
// Endpoint 0 host control and status constants
// ****************************************************************
package uhec_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] CSR_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] SVC_ADDR = 8'h04;

  // Control and status field positions
  localparam int BIT_UNLOCK = 10;
  localparam int BIT_TOGGLE = 9;
  localparam int BIT_DISCARD = 8;
  localparam int BIT_NAKHALT = 7;
  localparam int BIT_STATUS = 6;
  localparam int BIT_INREQ = 5;
  localparam int BIT_ERROR = 4;
  localparam int BIT_SETUP = 3;
  localparam int BIT_STALL = 2;
  localparam int BIT_TXLOAD = 1;
  localparam int BIT_RXAVAIL = 0;
  localparam int BIT_RXSVC = 0;

  // Values after reset
  localparam logic [DATA_W-1:0] CSR_RESET = 16'h0000;
  localparam logic FLAG_RESET = 1'b0;

  // Counts
  localparam int NAK_W = 8;
  localparam logic [1:0] NO_RESPONSE_LIMIT = 2'h3;

  typedef enum logic [1:0] {
    UHEC_KIND_SETUP = 2'b00,
    UHEC_KIND_OUT = 2'b01,
    UHEC_KIND_IN = 2'b10
  } uhec_kind_t;

  // Flag set by hardware, cleared by a zero written in its field
  function automatic logic uhec_sticky(input logic q, input logic set, input logic wr,
                                       input logic wbit);
    uhec_sticky = set | (q & ~(wr & ~wbit));
  endfunction : uhec_sticky

endpackage : uhec_pkg

// >>> common/uhec_txn_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Link outcome events between control logic and retry tracker
// ****************************************************************
interface uhec_txn_if #(parameter int NAK_W = 8);
  logic nak;
  logic no_response;
  logic responded;
  logic restart;
  logic [NAK_W-1:0] nak_limit;
  logic nak_expired;
  logic retry_exhausted;

  modport ctrl (output nak, output no_response, output responded, output restart,
                output nak_limit, input nak_expired, input retry_exhausted);
  modport tracker (input nak, input no_response, input responded, input restart,
                   input nak_limit, output nak_expired, output retry_exhausted);
endinterface : uhec_txn_if
`default_nettype wire

// >>> logic/uhec_retry_tracker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// NAK and no-response counting for the active transaction
// ****************************************************************
module uhec_retry_tracker
  import uhec_pkg::*;
#(
  parameter int NAK_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  uhec_txn_if.tracker txn
);

  logic [NAK_W-1:0] nak_cnt_q;
  logic [NAK_W-1:0] nak_cnt_d;
  logic [1:0] miss_cnt_q;
  logic [1:0] miss_cnt_d;
  wire logic clear_w;
  wire logic third_miss_w;

  assign clear_w = txn.restart | txn.responded;
  // Limit zero disables the NAK halt
  assign txn.nak_expired = txn.nak & (txn.nak_limit != '0) & (nak_cnt_q >= txn.nak_limit);
  assign third_miss_w = txn.no_response & (miss_cnt_q == NO_RESPONSE_LIMIT - 2'h1);
  assign txn.retry_exhausted = third_miss_w;

  assign nak_cnt_d = (clear_w | txn.nak_expired | txn.no_response) ? '0 :
                     txn.nak ? nak_cnt_q + 1'b1 : nak_cnt_q;
  assign miss_cnt_d = (clear_w | txn.nak | third_miss_w) ? 2'h0 :
                      txn.no_response ? miss_cnt_q + 2'h1 : miss_cnt_q;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      nak_cnt_q <= '0;
      miss_cnt_q <= 2'h0;
    end else begin
      nak_cnt_q <= nak_cnt_d;
      miss_cnt_q <= miss_cnt_d;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  a_miss_count_bound: assert property (miss_cnt_q < NO_RESPONSE_LIMIT)
    else $error("No-response count passed its limit");

endmodule : uhec_retry_tracker
`default_nettype wire

// >>> logic/uhec_ep0_ctrl.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Endpoint 0 host control and status
// ****************************************************************
module uhec_ep0_ctrl
  import uhec_pkg::*;
#(
  parameter int NAK_LIMIT_W = NAK_W
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [NAK_LIMIT_W-1:0] ep0_nak_limit_in,
  input wire logic link_ack_in,
  input wire logic link_data_rcvd_in,
  input wire logic link_stall_in,
  input wire logic link_nak_in,
  input wire logic link_no_response_in,
  output logic txn_req_out,
  output logic [1:0] txn_kind_out,
  output logic txn_data1_out,
  output logic fifo_discard_out,
  output logic ep0_event_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic toggle_q;
  logic toggle_d;
  logic unlock_q;
  logic unlock_d;
  logic nak_halt_q;
  logic nak_halt_d;
  logic status_q;
  logic status_d;
  logic in_req_q;
  logic in_req_d;
  logic error_q;
  logic error_d;
  logic setup_q;
  logic setup_d;
  logic stall_q;
  logic stall_d;
  logic tx_loaded_q;
  logic tx_loaded_d;
  logic rx_avail_q;
  logic rx_avail_d;
  logic discard_q;
  logic event_q;
  logic event_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  uhec_txn_if #(.NAK_W(NAK_LIMIT_W)) txn ();

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire logic csr_wr_w;
  wire logic svc_wr_w;
  wire logic csr_rd_w;
  wire logic toggle_wr_w;
  wire logic discard_req_w;
  wire logic discard_ok_w;
  wire logic rx_service_w;
  wire logic [DATA_W-1:0] csr_value_w;

  assign csr_wr_w = reg_wr_in & (reg_addr_in == CSR_ADDR);
  assign svc_wr_w = reg_wr_in & (reg_addr_in == SVC_ADDR);
  assign csr_rd_w = reg_rd_in & (reg_addr_in == CSR_ADDR);
  assign toggle_wr_w = csr_wr_w & unlock_q;
  assign discard_req_w = csr_wr_w & reg_wdata_in[BIT_DISCARD];
  assign discard_ok_w = discard_req_w & (tx_loaded_q | rx_avail_q);
  assign rx_service_w = svc_wr_w & reg_wdata_in[BIT_RXSVC];

  assign csr_value_w = {5'h00, unlock_q, toggle_q, 1'b0, nak_halt_q, status_q, in_req_q,
                        error_q, setup_q, stall_q, tx_loaded_q, rx_avail_q};

  // ****************************************************************
  // Transaction request and outcome
  // ****************************************************************
  wire logic halted_w;
  wire logic is_in_w;
  wire logic tx_done_w;
  wire logic rx_done_w;
  wire logic stall_ev_w;
  wire logic error_ev_w;

  assign halted_w = nak_halt_q | error_q | stall_q;
  assign txn_req_out = (tx_loaded_q | (in_req_q & ~rx_avail_q)) & ~halted_w;
  assign is_in_w = ~tx_loaded_q;
  assign txn_kind_out = is_in_w ? UHEC_KIND_IN :
                        setup_q ? UHEC_KIND_SETUP : UHEC_KIND_OUT;
  assign txn_data1_out = status_q | (~is_in_w & ~setup_q & toggle_q) |
                         (is_in_w & toggle_q);

  assign tx_done_w = txn_req_out & ~is_in_w & link_ack_in;
  assign rx_done_w = txn_req_out & is_in_w & link_data_rcvd_in;
  assign stall_ev_w = txn_req_out & link_stall_in;
  assign error_ev_w = txn_req_out & txn.retry_exhausted;

  assign txn.nak = txn_req_out & link_nak_in;
  assign txn.no_response = txn_req_out & link_no_response_in;
  assign txn.responded = txn_req_out & (link_ack_in | link_data_rcvd_in | link_stall_in);
  assign txn.restart = ~txn_req_out;
  assign txn.nak_limit = ep0_nak_limit_in;

  uhec_retry_tracker #(
    .NAK_W(NAK_LIMIT_W)
  ) u_tracker (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .txn(txn.tracker)
  );

  // ****************************************************************
  // Next-state selection
  // ****************************************************************
  assign unlock_d = toggle_wr_w ? 1'b0 : (csr_wr_w & reg_wdata_in[BIT_UNLOCK]) ? 1'b1 :
                    unlock_q;
  assign toggle_d = toggle_wr_w ? reg_wdata_in[BIT_TOGGLE] :
                    (tx_done_w | rx_done_w) ? ~txn_data1_out : toggle_q;

  assign tx_loaded_d = (tx_loaded_q & ~tx_done_w & ~discard_ok_w) |
                       (csr_wr_w & reg_wdata_in[BIT_TXLOAD] & ~reg_wdata_in[BIT_DISCARD]);
  assign rx_avail_d = rx_done_w | (rx_avail_q & ~rx_service_w & ~discard_ok_w);
  assign in_req_d = (in_req_q & ~rx_done_w) | (csr_wr_w & reg_wdata_in[BIT_INREQ]);
  assign status_d = csr_wr_w ? reg_wdata_in[BIT_STATUS] :
                    status_q & ~(tx_done_w | rx_done_w);
  assign setup_d = csr_wr_w ? reg_wdata_in[BIT_SETUP] : setup_q & ~tx_done_w;

  assign nak_halt_d = uhec_sticky(nak_halt_q, txn.nak_expired, csr_wr_w,
                                  reg_wdata_in[BIT_NAKHALT]);
  assign error_d = uhec_sticky(error_q, error_ev_w, csr_wr_w, reg_wdata_in[BIT_ERROR]);
  assign stall_d = uhec_sticky(stall_q, stall_ev_w, csr_wr_w, reg_wdata_in[BIT_STALL]);

  assign event_d = tx_done_w | rx_done_w | error_ev_w;
  assign rdata_d = csr_rd_w ? csr_value_w : CSR_RESET;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      toggle_q <= FLAG_RESET;
      unlock_q <= FLAG_RESET;
      nak_halt_q <= FLAG_RESET;
      status_q <= FLAG_RESET;
      in_req_q <= FLAG_RESET;
      error_q <= FLAG_RESET;
      setup_q <= FLAG_RESET;
      stall_q <= FLAG_RESET;
      tx_loaded_q <= FLAG_RESET;
      rx_avail_q <= FLAG_RESET;
    end else begin
      toggle_q <= toggle_d;
      unlock_q <= unlock_d;
      nak_halt_q <= nak_halt_d;
      status_q <= status_d;
      in_req_q <= in_req_d;
      error_q <= error_d;
      setup_q <= setup_d;
      stall_q <= stall_d;
      tx_loaded_q <= tx_loaded_d;
      rx_avail_q <= rx_avail_d;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      discard_q <= FLAG_RESET;
      event_q <= FLAG_RESET;
      rdata_q <= CSR_RESET;
    end else begin
      discard_q <= discard_ok_w;
      event_q <= event_d;
      rdata_q <= rdata_d;
    end
  end

  assign fifo_discard_out = discard_q;
  assign ep0_event_out = event_q;
  assign reg_rdata_out = rdata_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  sequence s_unlock_armed;
    csr_wr_w && reg_wdata_in[BIT_UNLOCK] && !unlock_q;
  endsequence

  sequence s_toggle_store;
    toggle_wr_w ##1 (!unlock_q && toggle_q == $past(reg_wdata_in[BIT_TOGGLE]));
  endsequence

  a_unlock_arm: assert property (s_unlock_armed |=> unlock_q)
    else $error("Unlock write did not arm the toggle");

  a_unlock_store_clear: assert property (toggle_wr_w |-> s_toggle_store)
    else $error("Unlock did not store the toggle and drop");

  a_unlock_idle: assert property (unlock_q && !csr_wr_w
    |=> unlock_q)
    else $error("Unlock dropped without a write");

  a_toggle_locked_write: assert property (csr_wr_w && !unlock_q && !tx_done_w && !rx_done_w
    |=> toggle_q == $past(toggle_q))
    else $error("Toggle changed by a locked write");

  sequence s_discard_taken;
    discard_ok_w ##1 (fifo_discard_out && !rx_avail_q);
  endsequence

  a_discard_effect: assert property (discard_ok_w && !reg_wdata_in[BIT_TXLOAD] |->
    s_discard_taken ##0 !tx_loaded_q)
    else $error("Discard did not pulse and clear the flags");

  a_discard_idle: assert property (discard_req_w && !tx_loaded_q && !rx_avail_q
    |=> !fifo_discard_out)
    else $error("Discard acted with no packet queued");

  a_nak_halt_stop: assert property (txn.nak_expired |=> nak_halt_q && !txn_req_out)
    else $error("NAK limit did not halt the endpoint");

  a_status_data1: assert property (txn_req_out && status_q |-> txn_data1_out)
    else $error("Status stage without DATA1");

  a_in_req_clear: assert property (rx_done_w && !(csr_wr_w && reg_wdata_in[BIT_INREQ])
    |=> rx_avail_q && !in_req_q)
    else $error("IN request not cleared by received data");

  a_error_event: assert property (error_ev_w |=> error_q && ep0_event_out && !txn_req_out)
    else $error("Third missed answer not reported");

  a_setup_token: assert property (txn_req_out && tx_loaded_q && setup_q
    |-> txn_kind_out == UHEC_KIND_SETUP && !txn_data1_out || status_q)
    else $error("SETUP token not selected");

  a_stall_flag: assert property (stall_ev_w |=> stall_q && !txn_req_out)
    else $error("STALL handshake not recorded");

  a_tx_done_event: assert property (tx_done_w && !csr_wr_w |=> !tx_loaded_q ##0
    ep0_event_out)
    else $error("Sent packet not cleared with an event");

  a_rx_service: assert property (rx_service_w && !rx_done_w |=> !rx_avail_q)
    else $error("Service request did not clear rx-available");

  a_sticky_hold: assert property (error_q && csr_wr_w && reg_wdata_in[BIT_ERROR]
    |=> error_q)
    else $error("Error flag lost on a written one");

  a_read_latency: assert property (csr_rd_w |=> reg_rdata_out == $past(csr_value_w))
    else $error("Read data not presented one cycle later");

  sequence s_rx_taken;
    rx_done_w ##1 (rx_avail_q && ep0_event_out);
  endsequence

  a_rx_set_event: assert property (rx_done_w
    |-> s_rx_taken)
    else $error("Received data did not set rx-available with an event");

  a_toggle_after_txn: assert property ((tx_done_w || rx_done_w) && !toggle_wr_w
    |=> toggle_q == !$past(txn_data1_out))
    else $error("Toggle did not advance after a completed transaction");

  a_in_gate_avail: assert property (in_req_q && rx_avail_q && !tx_loaded_q
    |-> !txn_req_out)
    else $error("IN requested while rx-available still set");

  a_no_req_idle: assert property (!tx_loaded_q && !in_req_q
    |-> !txn_req_out)
    else $error("Transaction requested with nothing pending");

  a_tx_priority: assert property (tx_loaded_q
    |-> txn_kind_out != UHEC_KIND_IN)
    else $error("IN token chosen while a packet is loaded");

  a_status_clear: assert property ((tx_done_w || rx_done_w) && !csr_wr_w
    |=> !status_q)
    else $error("Status stage request outlived its transaction");

  a_setup_clear: assert property (tx_done_w && !csr_wr_w
    |=> !setup_q)
    else $error("Setup select outlived its transaction");

  a_discard_flags: assert property (discard_ok_w
    |=> !tx_loaded_q && !rx_avail_q)
    else $error("Discard left a packet flag set");

  a_discard_single: assert property (fifo_discard_out
    |=> !fifo_discard_out)
    else $error("Discard pulse longer than one cycle");

  a_event_cause: assert property (!(tx_done_w || rx_done_w || error_ev_w)
    |=> !ep0_event_out)
    else $error("Event raised without a cause");

  a_nak_halt_hold: assert property (nak_halt_q && !csr_wr_w
    |=> nak_halt_q)
    else $error("NAK halt flag dropped without a write");

  a_stall_hold: assert property (stall_q && !csr_wr_w
    |=> stall_q)
    else $error("Stall flag dropped without a write");

  a_error_clear: assert property (csr_wr_w && !reg_wdata_in[BIT_ERROR]
    && !error_ev_w |=> !error_q)
    else $error("Error flag kept after a written zero");

  a_stall_clear: assert property (csr_wr_w && !reg_wdata_in[BIT_STALL]
    && !stall_ev_w |=> !stall_q)
    else $error("Stall flag kept after a written zero");

  a_rdata_idle: assert property (!csr_rd_w
    |=> reg_rdata_out == CSR_RESET)
    else $error("Read data not back to zero");

endmodule : uhec_ep0_ctrl
`default_nettype wire

// >>> verification/uhec_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Peripheral answering endpoint 0 transactions
// ****************************************************************
module uhec_peer_model
  import uhec_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic txn_req_in,
  input wire logic [1:0] txn_kind_in,
  input wire logic [1:0] mode_in,
  input wire logic [1:0] dly_in,
  output logic link_ack_out,
  output logic link_data_rcvd_out,
  output logic link_stall_out,
  output logic link_nak_out,
  output logic link_no_response_out
);
  logic [1:0] cnt_q;
  logic fire_q;
  logic is_in;

  // One answer per attempt, after a programmable wait, only while asked
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= 2'h0;
      fire_q <= 1'b0;
    end else if (!txn_req_in || fire_q) begin
      cnt_q <= 2'h0;
      fire_q <= 1'b0;
    end else if (cnt_q == dly_in) begin
      fire_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign is_in = (txn_kind_in == UHEC_KIND_IN);
  assign link_ack_out = fire_q && (mode_in == 2'h0) && !is_in;
  assign link_data_rcvd_out = fire_q && (mode_in == 2'h0) && is_in;
  assign link_stall_out = fire_q && (mode_in == 2'h1);
  assign link_nak_out = fire_q && (mode_in == 2'h2);
  assign link_no_response_out = fire_q && (mode_in == 2'h3);
endmodule : uhec_peer_model
`default_nettype wire

// >>> verification/usb_host_ep0_control_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Endpoint 0 host control bench
// ****************************************************************
module usb_host_ep0_control_status_tb_top;
  import uhec_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [ADDR_W-1:0] reg_addr_in = 8'h00;
  logic [DATA_W-1:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [NAK_W-1:0] nak_lim = 8'h00;
  logic [1:0] mode = 2'h0;
  logic [1:0] dly = 2'h0;
  logic [DATA_W-1:0] reg_rdata_out;
  logic ack, drcv, stl, nak, nrsp, txn_req_out, txn_data1_out, fifo_discard_out, ep0_event_out;
  logic [1:0] txn_kind_out;
  logic [DATA_W-1:0] exp_csr = 16'h0000;
  logic [DATA_W-1:0] v;
  logic tog = 1'b0;
  integer errors = 0, checks = 0, seed = 4, ev_n = 0, ev_exp = 0, disc_n = 0, nak_n = 0, lim;
  integer nrsp_n = 0;

  always #2 clk_sys_in = ~clk_sys_in;

  uhec_ep0_ctrl uhec_ep0_ctrl_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ep0_nak_limit_in(nak_lim),
    .link_ack_in(ack), .link_data_rcvd_in(drcv), .link_stall_in(stl), .link_nak_in(nak),
    .link_no_response_in(nrsp), .txn_req_out(txn_req_out), .txn_kind_out(txn_kind_out),
    .txn_data1_out(txn_data1_out), .fifo_discard_out(fifo_discard_out),
    .ep0_event_out(ep0_event_out));
  uhec_peer_model uhec_peer_model_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .txn_req_in(txn_req_out), .txn_kind_in(txn_kind_out), .mode_in(mode), .dly_in(dly),
    .link_ack_out(ack), .link_data_rcvd_out(drcv), .link_stall_out(stl),
    .link_nak_out(nak), .link_no_response_out(nrsp));

  always @(posedge clk_sys_in) begin
    if (ep0_event_out === 1'b1) ev_n = ev_n + 1;
    if (fifo_discard_out === 1'b1) disc_n = disc_n + 1;
    if (nak === 1'b1 && txn_req_out === 1'b1) nak_n = nak_n + 1;
    if (nrsp === 1'b1 && txn_req_out === 1'b1) nrsp_n = nrsp_n + 1;
  end

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    dly <= 2'($random(seed));
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : rd

  task automatic chk_csr(input logic [DATA_W-1:0] m);
    rd(CSR_ADDR, v);
    chk(v & m, exp_csr & m);
  endtask : chk_csr

  // Wait for the request to drop, then let the event pulse land
  task automatic wait_done;
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys_in);
      if (txn_req_out === 1'b0) break;
    end
    if (i == 400) errors = errors + 1;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask : wait_done

  initial begin
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    chk_csr(16'hFFFF);
    wr(8'h08, 16'h0002);
    chk({15'h0, txn_req_out}, 16'h0000);
    rd(8'h08, v);
    chk(v, 16'h0000);
    rd(SVC_ADDR, v);
    chk(v, 16'h0000);
    wr(CSR_ADDR, 16'h0400);
    exp_csr = 16'h0400;
    chk_csr(16'hFFFF);
    wr(CSR_ADDR, 16'h0200);
    tog = 1'b1;
    exp_csr = 16'h0200;
    chk_csr(16'hFFFF);
    wr(CSR_ADDR, 16'h0000);
    chk_csr(16'hFFFF);
    wr(CSR_ADDR, 16'h0002);
    chk({14'h0, txn_kind_out}, 16'h0001);
    chk({15'h0, txn_data1_out}, {15'h0, tog});
    wait_done;
    tog = ~tog;
    ev_exp = ev_exp + 1;
    exp_csr = {6'h00, tog, 9'h000};
    chk_csr(16'hFFFF);
    wr(CSR_ADDR, 16'h000A);
    chk({14'h0, txn_kind_out}, 16'h0000);
    chk({15'h0, txn_data1_out}, 16'h0000);
    wait_done;
    tog = 1'b1;
    ev_exp = ev_exp + 1;
    exp_csr = 16'h0200;
    chk_csr(16'hFFFF);
    chk(ev_n[15:0], ev_exp[15:0]);
    mode <= 2'h1;
    wr(CSR_ADDR, 16'h0002);
    wait_done;
    exp_csr = 16'h0006;
    chk_csr(16'h0006);
    wr(CSR_ADDR, 16'h0004);
    chk_csr(16'h0006);
    mode <= 2'h0;
    wr(CSR_ADDR, 16'h0000);
    exp_csr = 16'h0000;
    chk_csr(16'h0004);
    wait_done;
    tog = ~tog;
    ev_exp = ev_exp + 1;
    exp_csr = {6'h00, tog, 9'h000};
    chk_csr(16'hFFFF);
    wr(CSR_ADDR, 16'h0002);
    wait_done;
    tog = ~tog;
    ev_exp = ev_exp + 1;
    mode <= 2'h3;
    wr(CSR_ADDR, 16'h0002);
    wait_done;
    ev_exp = ev_exp + 1;
    exp_csr = 16'h0012;
    chk_csr(16'h0012);
    chk(nrsp_n[15:0], 16'h0003);
    chk(ev_n[15:0], ev_exp[15:0]);
    mode <= 2'h0;
    wr(CSR_ADDR, 16'h0002);
    wait_done;
    tog = ~tog;
    ev_exp = ev_exp + 1;
    exp_csr = {6'h00, tog, 9'h000};
    chk_csr(16'hFFFF);
    lim = ($random(seed) & 3) + 1;
    nak_lim <= lim[NAK_W-1:0];
    mode <= 2'h2;
    nak_n = 0;
    wr(CSR_ADDR, 16'h0020);
    wait_done;
    exp_csr = 16'h0080;
    chk_csr(16'h0080);
    chk(nak_n[15:0], lim[15:0] + 16'h0001);
    mode <= 2'h0;
    wr(CSR_ADDR, 16'h0020);
    wait_done;
    tog = ~tog;
    ev_exp = ev_exp + 1;
    exp_csr = {6'h00, tog, 9'h001};
    chk_csr(16'hFFFF);
    disc_n = 0;
    wr(CSR_ADDR, 16'h0100);
    repeat (2) @(posedge clk_sys_in);
    exp_csr = {6'h00, tog, 9'h000};
    chk(disc_n[15:0], 16'h0001);
    chk_csr(16'hFFFF);
    wr(CSR_ADDR, 16'h0100);
    repeat (2) @(posedge clk_sys_in);
    chk(disc_n[15:0], 16'h0001);
    wr(CSR_ADDR, 16'h0060);
    chk({15'h0, txn_data1_out}, 16'h0001);
    wait_done;
    ev_exp = ev_exp + 1;
    exp_csr = 16'h0001;
    chk_csr(16'hFFFF);
    wr(SVC_ADDR, 16'h0001);
    exp_csr = 16'h0000;
    chk_csr(16'hFFFF);
    chk(ev_n[15:0], ev_exp[15:0]);
    wrap_up();
  end

  initial begin
    #200000;
    errors = errors + 1;
    wrap_up();
  end
endmodule : usb_host_ep0_control_status_tb_top
`default_nettype wire
